// ---- src/rtc_ctrl_top.sv ----
`timescale 1ns/1ps
module rtc_ctrl_top
  import rtc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Oscillator clock domain
  input wire logic osc_clk_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Device pins
  input wire logic clkout_control_pin_in,
  output logic sub_clock_output_out,
  output logic interrupt_out_a_n_out,
  // Time counter side
  input wire logic sec_write_in,
  input wire logic carry_min_in,
  input wire logic carry_hour_in,
  input wire logic carry_month_in,
  input wire logic [7:0] hour_in,
  output logic sec_tick_out,
  output logic [7:0] hour_next_out,
  output logic hour_mode_24_out,
  // Oscillation adjustment register contents
  input wire logic [6:0] osc_adj_in,
  input wire logic osc_adj_dev_in,
  output logic power_on_flag_out,
  // Alarm side
  input wire logic alarm_w_match_in,
  input wire logic alarm_d_match_in,
  output logic alarm_w_flag_out,
  output logic alarm_d_flag_out,
  // Supply monitor and oscillator status
  input wire logic supply_below_16_in,
  input wire logic supply_below_13_in,
  input wire logic osc_halt_in,
  output logic supply_monitor_on_out,
  output logic test_mode_out
);
  // Control register one, whole byte
  logic [7:0] ctrl_one_reg;
  // Control register two, bit by bit
  logic supply_threshold_select_reg;
  logic low_supply_flag_reg;
  logic osc_running_status_reg;
  logic power_on_flag_reg;
  logic clkout_disable_a_reg;
  logic periodic_irq_flag_reg;
  // Selector now in force
  logic [2:0] sel_act_reg;
  // Crossing bookkeeping
  logic sec_seen_reg; // Last seconds toggle handled
  logic low2_prev_reg; // Previous 2 Hz phase
  logic div_clear_tgl_reg; // Toggle to the oscillator domain
  // Oscillator domain results
  logic osc_low1;
  logic osc_low2;
  logic osc_sec_tgl;
  // Synced inputs
  logic [7:0] in_s;

  // Timebase on the oscillator clock
  rtc_osc_div u_div (
    .osc_clk_in(osc_clk_in),
    .nrst_in(nrst_in),
    .div_clear_tgl_in(div_clear_tgl_reg),
    .adj_value_in(osc_adj_in),
    .adj_dev_in(osc_adj_dev_in),
    .low_1hz_out(osc_low1),
    .low_2hz_out(osc_low2),
    .sec_tgl_out(osc_sec_tgl)
  );

  // Pins and oscillator-domain levels crossed by two flops each
  rtc_sync #(.WIDTH(8)) u_in_sync (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .en_in(clk_en_in),
    .async_in({clkout_control_pin_in, osc_halt_in, supply_below_16_in,
               supply_below_13_in, osc_clk_in, osc_low1, osc_low2, osc_sec_tgl}),
    .sync_out(in_s)
  );

  // Named synced signals
  wire clkout_control_pin_s = in_s[7];
  wire halt_s = in_s[6];
  wire below16_s = in_s[5];
  wire below13_s = in_s[4];
  wire osc_s = in_s[3];
  wire low1_s = in_s[2];
  wire low2_s = in_s[1];
  wire sec_tgl_s = in_s[0];

  // Timebase events in the register domain
  wire tick = sec_tgl_s ^ sec_seen_reg;
  wire half_edge = low2_s ^ low2_prev_reg;

  // Register access decode
  wire wr_one = reg_wr_in && (reg_addr_in == ADDR_CTRL_ONE);
  wire wr_two = reg_wr_in && (reg_addr_in == ADDR_CTRL_TWO);
  wire power_on_flag = power_on_flag_reg;

  // Control register one fields
  wire weekly_alarm_enable = ctrl_one_reg[C1_WEEKLY_ALARM_EN];
  wire daily_alarm_enable = ctrl_one_reg[C1_DAILY_ALARM_EN];
  wire hour_24 = ctrl_one_reg[C1_HOUR_24];
  wire clkout_disable_b = ctrl_one_reg[C1_CLKOUT_DIS_B];
  wire [2:0] sel_new = ctrl_one_reg[C1_SEL_HI:C1_SEL_LO];

  // Waveform class of the selector in force
  wire pulse_mode = (sel_act_reg == PER_PULSE_2HZ) || (sel_act_reg == PER_PULSE_1HZ);
  wire level_mode = sel_act_reg[2];
  wire pulse_low = (sel_act_reg == PER_PULSE_2HZ) ? low2_s : low1_s;

  // Level-mode event per selector
  logic level_hit;
  always_comb begin
    case (sel_act_reg)
      PER_LVL_SEC: level_hit = 1'b1;
      PER_LVL_MIN: level_hit = carry_min_in;
      PER_LVL_HOUR: level_hit = carry_hour_in;
      PER_LVL_MONTH: level_hit = carry_month_in;
      default: level_hit = 1'b0;
    endcase
  end
  wire level_evt = tick && level_mode && level_hit;

  // Periodic flag; a set in the same cycle wins over a clear
  wire periodic_irq_flag_set = level_evt || (pulse_mode && pulse_low) || (sel_act_reg == PER_FIXED_LOW);
  wire periodic_irq_flag_wr_clr = wr_two && level_mode && !reg_wdata_in[C2_PERIODIC_FLAG];
  wire periodic_irq_flag_clr = periodic_irq_flag_wr_clr || (pulse_mode && !pulse_low) || (sel_act_reg == PER_OFF);
  wire periodic_irq_flag_next = power_on_flag ? 1'b0 : periodic_irq_flag_set ? 1'b1 : periodic_irq_flag_clr ? 1'b0 : periodic_irq_flag_reg;

  // Supply monitor, sampled on the seconds tick only while armed
  wire below_sel = supply_threshold_select_reg ? below13_s : below16_s;
  wire low_supply_flag_set = tick && !low_supply_flag_reg && below_sel;
  wire low_supply_flag_clr = wr_two && !reg_wdata_in[C2_LOW_SUPPLY];
  wire low_supply_flag_next = power_on_flag ? 1'b0 : low_supply_flag_set ? 1'b1 : low_supply_flag_clr ? 1'b0 : low_supply_flag_reg;

  // Alarm flags read as zero while their channel is disabled
  wire wafg_next = (power_on_flag || !weekly_alarm_enable) ? 1'b0 :
                   alarm_w_match_in ? 1'b1 :
                   (wr_two && !reg_wdata_in[C2_WEEKLY_FLAG]) ? 1'b0 : alarm_w_flag_out;
  wire dafg_next = (power_on_flag || !daily_alarm_enable) ? 1'b0 :
                   alarm_d_match_in ? 1'b1 :
                   (wr_two && !reg_wdata_in[C2_DAILY_FLAG]) ? 1'b0 : alarm_d_flag_out;

  // Oscillator halt wins over a write of one
  wire xst_next = halt_s ? 1'b0 : wr_two ? reg_wdata_in[C2_OSC_RUNNING] : osc_running_status_reg;

  // Power-on flag accepts only a write of zero
  wire pon_next = (wr_two && !reg_wdata_in[C2_POWER_ON]) ? 1'b0 : power_on_flag_reg;

  // Sub clock gate
  wire clkout_on = clkout_control_pin_s && !(clkout_disable_a_reg && clkout_disable_b);

  // Read image of control register two
  wire [7:0] ctrl_two_img = {supply_threshold_select_reg, low_supply_flag_reg,
                             osc_running_status_reg, power_on_flag_reg, clkout_disable_a_reg,
                             periodic_irq_flag_reg, alarm_w_flag_out, alarm_d_flag_out};
  wire [7:0] rdata_next = (reg_addr_in == ADDR_CTRL_ONE) ? ctrl_one_reg :
                          (reg_addr_in == ADDR_CTRL_TWO) ? ctrl_two_img : 8'h00;

  // Control register one; held at zero while the power-on flag stands
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_one_reg <= CTRL_ONE_RST;
    end else if (clk_en_in) begin
      if (power_on_flag) ctrl_one_reg <= CTRL_ONE_RST;
      else if (wr_one) ctrl_one_reg <= reg_wdata_in;
    end
  end

  // Control register two plain bits
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      supply_threshold_select_reg <= 1'b0;
      clkout_disable_a_reg <= 1'b0;
      osc_running_status_reg <= 1'b0; // Undefined at power-up, zero chosen
      power_on_flag_reg <= 1'b1;
    end else if (clk_en_in) begin
      if (power_on_flag) begin
        supply_threshold_select_reg <= 1'b0;
        clkout_disable_a_reg <= 1'b0;
      end else if (wr_two) begin
        supply_threshold_select_reg <= reg_wdata_in[C2_THRESH_SEL];
        clkout_disable_a_reg <= reg_wdata_in[C2_CLKOUT_DIS_A];
      end
      osc_running_status_reg <= xst_next;
      power_on_flag_reg <= pon_next;
    end
  end

  // Event flags and the interrupt and monitor pins, each pin from its flag's next value
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      periodic_irq_flag_reg <= 1'b0;
      low_supply_flag_reg <= 1'b0;
      alarm_w_flag_out <= 1'b0;
      alarm_d_flag_out <= 1'b0;
      interrupt_out_a_n_out <= 1'b1;
      supply_monitor_on_out <= 1'b1;
    end else if (clk_en_in) begin
      periodic_irq_flag_reg <= periodic_irq_flag_next;
      low_supply_flag_reg <= low_supply_flag_next;
      alarm_w_flag_out <= wafg_next;
      alarm_d_flag_out <= dafg_next;
      interrupt_out_a_n_out <= !periodic_irq_flag_next;
      supply_monitor_on_out <= !low_supply_flag_next;
    end
  end

  // Selector switch only on a timebase event, so the pin cannot glitch
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_act_reg <= SEL_RST;
    end else if (clk_en_in) begin
      if (power_on_flag) sel_act_reg <= SEL_RST;
      else if (tick || half_edge) sel_act_reg <= sel_new;
    end
  end

  // Crossing bookkeeping and seconds toggle to the divider
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_seen_reg <= 1'b0;
      low2_prev_reg <= 1'b0;
      div_clear_tgl_reg <= 1'b0;
      sec_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      sec_seen_reg <= sec_tgl_s;
      low2_prev_reg <= low2_s;
      if (sec_write_in) div_clear_tgl_reg <= ~div_clear_tgl_reg;
      sec_tick_out <= tick;
    end
  end

  // Registered side outputs
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
      sub_clock_output_out <= 1'b0;
      hour_next_out <= 8'h00;
      hour_mode_24_out <= 1'b0;
      power_on_flag_out <= 1'b1;
      test_mode_out <= 1'b0;
    end else if (clk_en_in) begin
      if (reg_rd_in) reg_rdata_out <= rdata_next;
      sub_clock_output_out <= clkout_on && osc_s;
      hour_next_out <= rtc_next_hour(hour_in, hour_24);
      hour_mode_24_out <= hour_24;
      power_on_flag_out <= pon_next;
      test_mode_out <= ctrl_one_reg[C1_TEST];
    end
  end

  // Power-on flag keeps the control bits at zero
  a_pon_forces_zero: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    power_on_flag && clk_en_in |=> ctrl_one_reg == CTRL_ONE_RST && !periodic_irq_flag_reg
    && !low_supply_flag_reg)
    else $error("control bits not cleared under power-on flag");

  // Level event drives the pin low with the seconds tick
  a_level_evt_low: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && level_evt && !power_on_flag |=> !interrupt_out_a_n_out && sec_tick_out)
    else $error("level event did not assert pin with tick");

  // Flag clear in level mode releases the pin
  a_periodic_irq_flag_release: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && periodic_irq_flag_wr_clr && !level_evt |=> interrupt_out_a_n_out && !periodic_irq_flag_reg)
    else $error("flag clear did not release pin");

  // Low-supply flag holds until cleared by a zero write
  a_low_supply_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && low_supply_flag_reg && !low_supply_flag_clr && !power_on_flag
    |=> low_supply_flag_reg && !supply_monitor_on_out)
    else $error("low-supply flag dropped without a clear");

  // Writing one to a clear flag changes nothing
  a_low_supply_flag_one_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && wr_two && reg_wdata_in[C2_LOW_SUPPLY] && !low_supply_flag_reg && !low_supply_flag_set
    |=> !low_supply_flag_reg)
    else $error("write of one set the low-supply flag");

  // Sub clock held low when gated off
  a_clkout_gated: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && (!clkout_control_pin_s || (clkout_disable_a_reg && clkout_disable_b))
    |=> !sub_clock_output_out)
    else $error("sub clock ran while disabled");

  // Disabled weekly alarm channel reads zero
  a_alarm_disabled: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && !weekly_alarm_enable |=> !alarm_w_flag_out)
    else $error("weekly flag set while channel disabled");

  // Pulse modes follow the divider phase
  a_pulse_follow: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && pulse_mode && !power_on_flag |=> interrupt_out_a_n_out == !$past(pulse_low))
    else $error("pulse output does not follow the divider");

  // Off code keeps the pin high
  a_off_high: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    clk_en_in && sel_act_reg == PER_OFF |=> interrupt_out_a_n_out)
    else $error("pin low while selector is off");
endmodule : rtc_ctrl_top

// ---- src/rtc_pkg.sv ----
package rtc_pkg;

  // Register addresses on the documented register port
  localparam logic [3:0] ADDR_CTRL_ONE = 4'he;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'hf;

  // Field positions, rtc_control_one
  localparam int C1_WEEKLY_ALARM_EN = 7;
  localparam int C1_DAILY_ALARM_EN = 6;
  localparam int C1_HOUR_24 = 5;
  localparam int C1_CLKOUT_DIS_B = 4;
  localparam int C1_TEST = 3;
  localparam int C1_SEL_HI = 2;
  localparam int C1_SEL_LO = 0;

  // Field positions, rtc_control_two
  localparam int C2_THRESH_SEL = 7;
  localparam int C2_LOW_SUPPLY = 6;
  localparam int C2_OSC_RUNNING = 5;
  localparam int C2_POWER_ON = 4;
  localparam int C2_CLKOUT_DIS_A = 3;
  localparam int C2_PERIODIC_FLAG = 2;
  localparam int C2_WEEKLY_FLAG = 1;
  localparam int C2_DAILY_FLAG = 0;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [2:0] SEL_RST = 3'h0;

  // Periodic selector codes
  localparam logic [2:0] PER_OFF = 3'h0;
  localparam logic [2:0] PER_FIXED_LOW = 3'h1;
  localparam logic [2:0] PER_PULSE_2HZ = 3'h2;
  localparam logic [2:0] PER_PULSE_1HZ = 3'h3;
  localparam logic [2:0] PER_LVL_SEC = 3'h4;
  localparam logic [2:0] PER_LVL_MIN = 3'h5;
  localparam logic [2:0] PER_LVL_HOUR = 3'h6;
  localparam logic [2:0] PER_LVL_MONTH = 3'h7;

  // Timebase of the 32.768 kHz oscillator
  localparam int OSC_HZ = 32768;
  localparam int SEC_DELAY_US = 92;
  localparam int SEC_DELAY_RAW = (OSC_HZ * SEC_DELAY_US) / 1000000;
  localparam logic [15:0] SEC_DELAY_CYC = 16'((SEC_DELAY_RAW < 1) ? 1 : SEC_DELAY_RAW);
  localparam logic [15:0] DIV_BASE = 16'h0100;
  localparam logic [15:0] DIV_TERM = 16'(256 + OSC_HZ - 1);
  localparam logic [15:0] DIV_HALF = 16'(256 + OSC_HZ / 2);
  localparam logic [15:0] DIV_QUART = 16'(256 + OSC_HZ / 4);
  localparam logic [15:0] DIV_3QUART = 16'(256 + (3 * OSC_HZ) / 4);

  // Adjustment period in seconds
  localparam int ADJ_SHORT_S = 20;
  localparam int ADJ_LONG_S = 60;
  localparam logic [5:0] ADJ_SHORT_LAST = 6'(ADJ_SHORT_S - 1);
  localparam logic [5:0] ADJ_LONG_LAST = 6'(ADJ_LONG_S - 1);

  // Hour codes in BCD
  localparam logic [7:0] HOUR24_LAST = 8'h23;
  localparam logic [7:0] HOUR24_FIRST = 8'h00;
  localparam logic [7:0] HOUR_AM11 = 8'h11;
  localparam logic [7:0] HOUR_AM12 = 8'h12;
  localparam logic [7:0] HOUR_AM1 = 8'h01;
  localparam logic [7:0] HOUR_PM11 = 8'h31;
  localparam logic [7:0] HOUR_PM12 = 8'h32;
  localparam logic [7:0] HOUR_PM1 = 8'h21;

  // Plain BCD increment of two digits
  function automatic logic [7:0] rtc_bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : rtc_bcd_inc

  // Next hour code in the chosen format
  function automatic logic [7:0] rtc_next_hour(input logic [7:0] h, input logic mode24);
    logic [7:0] r;
    r = rtc_bcd_inc(h);
    if (mode24) begin
      if (h == HOUR24_LAST) r = HOUR24_FIRST;
    end else begin
      case (h)
        HOUR_AM11: r = HOUR_PM12;
        HOUR_AM12: r = HOUR_AM1;
        HOUR_PM11: r = HOUR_AM12;
        HOUR_PM12: r = HOUR_PM1;
        default: r = rtc_bcd_inc(h);
      endcase
    end
    return r;
  endfunction : rtc_next_hour

endpackage : rtc_pkg

// ---- src/rtc_sync.sv ----
`timescale 1ns/1ps
module rtc_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic en_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta_reg;

  // Two-flop crossing per bit
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (en_in) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rtc_sync

// ---- src/rtc_osc_div.sv ----
`timescale 1ns/1ps
module rtc_osc_div
  import rtc_pkg::*;
(
  // Oscillator domain
  input wire logic osc_clk_in,
  input wire logic nrst_in,
  // From the register domain
  input wire logic div_clear_tgl_in,
  input wire logic [6:0] adj_value_in,
  input wire logic adj_dev_in,
  // Timebase results
  output logic low_1hz_out,
  output logic low_2hz_out,
  output logic sec_tgl_out
);
  logic [8:0] cfg_s; // Synced {clear toggle, dev, value}
  logic clr_seen_reg; // Last clear toggle handled
  logic [15:0] cnt_reg; // Sub-second divider
  logic [15:0] start_reg; // Start point of this second
  logic [5:0] sec_cnt_reg; // Seconds since last adjustment

  rtc_sync #(.WIDTH(9)) u_cfg_sync (
    .clk_in(osc_clk_in),
    .nrst_in(nrst_in),
    .en_in(1'b1),
    .async_in({div_clear_tgl_in, adj_dev_in, adj_value_in}),
    .sync_out(cfg_s)
  );

  // Decode of divider events
  wire clr_evt = cfg_s[8] ^ clr_seen_reg;
  wire wrap = (cnt_reg == DIV_TERM);
  wire adj_due = (sec_cnt_reg == (cfg_s[7] ? ADJ_LONG_LAST : ADJ_SHORT_LAST));
  // Signed step of two cycles per unit stretches or shrinks the low phase
  wire [15:0] adj_step = {{8{cfg_s[6]}}, cfg_s[6:0], 1'b0};
  wire [15:0] start_next = adj_due ? (DIV_BASE - adj_step) : DIV_BASE;
  wire tick = (cnt_reg == start_reg + SEC_DELAY_CYC);
  wire low1 = (cnt_reg < DIV_HALF);
  wire low2 = (cnt_reg < DIV_QUART) || ((cnt_reg >= DIV_HALF) && (cnt_reg < DIV_3QUART));

  // Divider and adjustment counter
  always_ff @(posedge osc_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_seen_reg <= 1'b0;
      cnt_reg <= DIV_BASE;
      start_reg <= DIV_BASE;
      sec_cnt_reg <= '0;
    end else if (clr_evt) begin
      // Seconds write restarts the sub-second stages in the low phase
      clr_seen_reg <= cfg_s[8];
      cnt_reg <= DIV_BASE;
      start_reg <= DIV_BASE;
      sec_cnt_reg <= '0;
    end else if (wrap) begin
      cnt_reg <= start_next;
      start_reg <= start_next;
      sec_cnt_reg <= adj_due ? 6'h00 : sec_cnt_reg + 6'h01;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Registered outputs, crossed by the register domain
  always_ff @(posedge osc_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_1hz_out <= 1'b0;
      low_2hz_out <= 1'b0;
      sec_tgl_out <= 1'b0;
    end else begin
      low_1hz_out <= low1;
      low_2hz_out <= low2;
      if (tick) sec_tgl_out <= ~sec_tgl_out;
    end
  end
endmodule : rtc_osc_div

// ---- tb/rtc_osc_model.sv ----
`timescale 1ns/1ps
module rtc_osc_model #(
  parameter realtime HALF = 32.0
) (
  // Crystal pin
  output logic osc_clk_out
);
  // Free-running crystal, phase unrelated to the register clock
  initial begin
    osc_clk_out = 1'b0;
    #7.3;
    forever #HALF osc_clk_out = ~osc_clk_out;
  end
endmodule : rtc_osc_model

// ---- tb/tb_rtc_ctrl_top.sv ----
`timescale 1ns/1ps
module tb_rtc_ctrl_top;
  import rtc_pkg::*;
  // Clock, reset, enable
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic osc_clk_in;
  // Register port
  logic [3:0] reg_addr_in = 4'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  // Pins and side inputs; seconds writes stand in for the slow timebase
  logic clkout_control_pin_in = 1'b1;
  logic sub_clock_output_out, interrupt_out_a_n_out;
  logic sec_write_in = 1'b0;
  logic carry_min_in = 1'b0;
  logic carry_hour_in = 1'b0;
  logic carry_month_in = 1'b0;
  logic [7:0] hour_in = 8'h00;
  logic [7:0] hour_next_out;
  logic hour_mode_24_out, power_on_flag_out, test_mode_out, sec_tick_out;
  logic [6:0] osc_adj_in = 7'h00;
  logic osc_adj_dev_in = 1'b0;
  logic alarm_w_match_in = 1'b0;
  logic alarm_d_match_in = 1'b0;
  logic alarm_w_flag_out, alarm_d_flag_out, supply_monitor_on_out;
  logic supply_below_16_in = 1'b0;
  logic supply_below_13_in = 1'b0;
  logic osc_halt_in = 1'b0;
  // Score and watchdog
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int ticks = 0; // Seconds increments seen
  int t0 = 0; // Tick count at the last seconds write

  rtc_osc_model rtc_osc_model_i (.osc_clk_out(osc_clk_in));
  rtc_ctrl_top rtc_ctrl_top_i (
    .ref_clk_in, .nrst_in, .clk_en_in, .osc_clk_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .clkout_control_pin_in,
    .sub_clock_output_out, .interrupt_out_a_n_out, .sec_write_in, .carry_min_in,
    .carry_hour_in, .carry_month_in, .hour_in, .sec_tick_out, .hour_next_out,
    .hour_mode_24_out, .osc_adj_in, .osc_adj_dev_in, .power_on_flag_out,
    .alarm_w_match_in, .alarm_d_match_in, .alarm_w_flag_out, .alarm_d_flag_out,
    .supply_below_16_in, .supply_below_13_in, .osc_halt_in,
    .supply_monitor_on_out, .test_mode_out);

  // 200 MHz register clock
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_n

  // One write strobe, released on the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data lands on the edge that takes the strobe; checked one edge later
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    wait_n(1);
    chk(n, e, reg_rdata_out);
  endtask : rd

  // Settle past the synchronisers; a running clock shows both levels
  task automatic sub_clk(input string n, input logic e);
    logic hi;
    logic lo;
    hi = 1'b0;
    lo = 1'b0;
    wait_n(10);
    repeat (40) begin
      wait_n(1);
      hi = hi | sub_clock_output_out;
      lo = lo | !sub_clock_output_out;
    end
    chk(n, {6'h00, e, 1'b1}, {6'h00, hi, lo});
  endtask : sub_clk

  task automatic hr(input logic [7:0] h, input logic [7:0] e);
    @(posedge ref_clk_in);
    hour_in <= h;
    wait_n(3);
    chk("hour_next", e, hour_next_out);
  endtask : hr

  // Seconds write restarts the divider; exactly one tick must follow
  task automatic sec_wr;
    t0 = ticks;
    @(posedge ref_clk_in);
    sec_write_in <= 1'b1;
    @(posedge ref_clk_in);
    sec_write_in <= 1'b0;
    wait_n(150);
    chk("tick", 8'h01, 8'(ticks - t0));
  endtask : sec_wr

  // Selector write, taking force at the tick of the next seconds write
  task automatic sel_go(input string n, input logic [2:0] s, input logic e);
    wr(ADDR_CTRL_ONE, {5'h00, s});
    sec_wr();
    chk(n, {7'h00, e}, {7'h00, interrupt_out_a_n_out});
  endtask : sel_go

  // Seconds increments, sampled half a cycle after launch
  always @(negedge ref_clk_in) begin
    if (sec_tick_out === 1'b1) ticks++;
  end

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few thousand cycles the tests need
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    wait_n(2);
    chk("pon_out", 8'h01, {7'h00, power_on_flag_out});
    chk("irq_pin", 8'h01, {7'h00, interrupt_out_a_n_out});
    rd("two_rst", ADDR_CTRL_TWO, 8'h10);
    wr(ADDR_CTRL_ONE, 8'hff);
    rd("one_forced", ADDR_CTRL_ONE, 8'h00);
    sub_clk("clk_pon", 1'b1);
    $display("test power_on done");
    wr(ADDR_CTRL_TWO, 8'h00);
    rd("pon_clr", ADDR_CTRL_TWO, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h27);
    rd("one_rw", ADDR_CTRL_ONE, 8'h27);
    chk("mode24", 8'h01, {7'h00, hour_mode_24_out});
    chk("test", 8'h00, {7'h00, test_mode_out});
    // Every selector code reads back
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL_ONE, {5'h04, c[2:0]});
      rd("sel", ADDR_CTRL_ONE, {5'h04, c[2:0]});
    end
    hr(8'h23, 8'h00);
    hr(8'h09, 8'h10);
    wr(ADDR_CTRL_ONE, 8'h00);
    hr(8'h11, 8'h32);
    hr(8'h12, 8'h01);
    hr(8'h31, 8'h12);
    hr(8'h32, 8'h21);
    $display("test control_one done");
    wr(ADDR_CTRL_ONE, 8'h10);
    sub_clk("one_dis", 1'b1);
    wr(ADDR_CTRL_TWO, 8'h08);
    sub_clk("both_dis", 1'b0);
    wr(ADDR_CTRL_ONE, 8'h00);
    clkout_control_pin_in <= 1'b0;
    sub_clk("pin_low", 1'b0);
    @(posedge ref_clk_in);
    clkout_control_pin_in <= 1'b1;
    $display("test sub_clock done");
    // Flags refuse ones; threshold select sticks
    wr(ADDR_CTRL_TWO, 8'hc7);
    rd("ones", ADDR_CTRL_TWO, 8'h80);
    @(posedge ref_clk_in);
    supply_below_16_in <= 1'b1;
    wait_n(20);
    chk("mon_on", 8'h01, {7'h00, supply_monitor_on_out});
    rd("no_tick", ADDR_CTRL_TWO, 8'h80);
    wr(ADDR_CTRL_TWO, 8'h20);
    rd("osc_ok", ADDR_CTRL_TWO, 8'h20);
    @(posedge ref_clk_in);
    osc_halt_in <= 1'b1;
    wait_n(10);
    rd("osc_halt", ADDR_CTRL_TWO, 8'h00);
    @(posedge ref_clk_in);
    osc_halt_in <= 1'b0;
    $display("test control_two done");
    // Only the enabled alarm channel raises its flag
    wr(ADDR_CTRL_ONE, 8'h80);
    alarm_w_match_in <= 1'b1;
    alarm_d_match_in <= 1'b1;
    @(posedge ref_clk_in);
    alarm_w_match_in <= 1'b0;
    alarm_d_match_in <= 1'b0;
    wait_n(2);
    chk("w_flag", 8'h01, {7'h00, alarm_w_flag_out});
    chk("d_flag", 8'h00, {7'h00, alarm_d_flag_out});
    rd("alarm_img", ADDR_CTRL_TWO, 8'h02);
    wr(ADDR_CTRL_ONE, 8'h00);
    wait_n(2);
    chk("w_off", 8'h00, {7'h00, alarm_w_flag_out});
    // Frozen clock enable drops the write
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    wr(ADDR_CTRL_ONE, 8'h20);
    clk_en_in <= 1'b1;
    rd("frozen", ADDR_CTRL_ONE, 8'h00);
    rd("unmapped", 4'h3, 8'h00);
    $display("test alarm_misc done");
    // Periodic pin; a seconds write brings each selector into force
    sel_go("lvl_take", PER_LVL_SEC, 1'b1);
    chk("mon_off", 8'h00, {7'h00, supply_monitor_on_out});
    rd("sampled", ADDR_CTRL_TWO, 8'h40);
    @(posedge ref_clk_in);
    supply_below_16_in <= 1'b0;
    sec_wr();
    chk("lvl_sec", 8'h00, {7'h00, interrupt_out_a_n_out});
    rd("lvl_img", ADDR_CTRL_TWO, 8'h44);
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_n(1);
    chk("lvl_clr", 8'h01, {7'h00, interrupt_out_a_n_out});
    chk("mon_rst", 8'h01, {7'h00, supply_monitor_on_out});
    for (int c = 5; c < 8; c++) begin
      sel_go("lvl_switch", c[2:0], 1'b0);
      wr(ADDR_CTRL_TWO, 8'h00);
      carry_min_in <= (c != 5);
      carry_hour_in <= (c != 6);
      carry_month_in <= (c != 7);
      sec_wr();
      chk("lvl_miss", 8'h01, {7'h00, interrupt_out_a_n_out});
      @(posedge ref_clk_in);
      carry_min_in <= (c == 5);
      carry_hour_in <= (c == 6);
      carry_month_in <= (c == 7);
      sec_wr();
      chk("lvl_hit", 8'h00, {7'h00, interrupt_out_a_n_out});
    end
    wr(ADDR_CTRL_TWO, 8'h00);
    carry_min_in <= 1'b0;
    carry_hour_in <= 1'b0;
    carry_month_in <= 1'b0;
    sel_go("pulse_2hz", PER_PULSE_2HZ, 1'b0);
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_n(1);
    chk("pulse_keep", 8'h00, {7'h00, interrupt_out_a_n_out});
    sel_go("pulse_1hz", PER_PULSE_1HZ, 1'b0);
    sel_go("fixed_low", PER_FIXED_LOW, 1'b0);
    sel_go("off", PER_OFF, 1'b1);
    $display("test periodic done");
    print_verdict();
  end
endmodule : tb_rtc_ctrl_top
